// ---- rtl/pib_pkg.sv ----
// Purpose: Shared constants and types for the host to ISA window bridge
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes:   Windows 0..5 forward I/O, windows 6..9 forward memory
package pib_pkg;

   // ----------------------------------------------------------------
   // Clock and cycle timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int CMD_MIN_NS = 250;   // Least command strobe width
   localparam int REC_MIN_NS = 100;   // Least idle time between cycles
   localparam int CMD_CYC = (CMD_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int REC_CYC = (REC_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 4;

   // ----------------------------------------------------------------
   // Window table layout
   // ----------------------------------------------------------------
   localparam int NUM_IO_WIN = 6;
   localparam int NUM_MEM_WIN = 4;
   localparam int NUM_WIN = NUM_IO_WIN + NUM_MEM_WIN;
   localparam int WIN_IDX_W = 4;
   localparam int ISA_AW = 24;
   localparam int ISA_DW = 16;

   // Reset contents of the windows set up at boot
   localparam logic [31:0] IO0_BASE = 32'h0000_0300;
   localparam logic [31:0] IO0_LIMIT = 32'h0000_031f;
   localparam logic [31:0] IO1_BASE = 32'h0000_8000;
   localparam logic [31:0] IO1_LIMIT = 32'h0000_80ff;
   localparam logic [31:0] MEM0_BASE = 32'h2000_0000;
   localparam logic [31:0] MEM0_LIMIT = 32'h200f_ffff;
   localparam logic [23:0] MEM0_XLAT = 24'h00_0000;
   localparam int IO0_IDX = 0;
   localparam int IO1_IDX = 1;
   localparam int MEM0_IDX = NUM_IO_WIN;

   // Top of the low megabyte on the ISA side
   localparam logic [23:0] LOW_MEG_TOP = 24'h0f_ffff;

   // ----------------------------------------------------------------
   // Routed interrupt lines
   // ----------------------------------------------------------------
   localparam int NUM_IRQ_OUT = 6;
   localparam int IRQ_SEL [NUM_IRQ_OUT] = '{1, 3, 4, 6, 7, 12};

   // ----------------------------------------------------------------
   // Cycle engine states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_CMD,
      ST_END,
      ST_REC
   } pib_state_t;

endpackage

// ---- rtl/pib_win.sv ----
// Purpose: Forwarding window table and address match
// Assumes: Config writes arrive as single-cycle strobes
// Notes:   Lowest-numbered matching window of the right type wins
`timescale 1ns/100ps
`default_nettype none
module pib_win
   import pib_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic cfg_we,
   input wire logic [pib_pkg::WIN_IDX_W-1:0] cfg_idx,
   input wire logic cfg_en,
   input wire logic [31:0] cfg_base,
   input wire logic [31:0] cfg_limit,
   input wire logic [pib_pkg::ISA_AW-1:0] cfg_xlat,
   input wire logic look_io,
   input wire logic [31:0] look_addr,
   output logic hit,
   output logic [pib_pkg::ISA_AW-1:0] hit_isa_addr
);
   import pib_pkg::*;

   typedef struct packed {
      logic [NUM_WIN-1:0] en;
      logic [NUM_WIN-1:0][31:0] base;
      logic [NUM_WIN-1:0][31:0] limit;
      logic [NUM_WIN-1:0][ISA_AW-1:0] xlat;
   } pib_win_st_t;

   pib_win_st_t s_r;
   pib_win_st_t s_nxt;
   logic [NUM_WIN-1:0] match;
   logic [NUM_WIN-1:0][ISA_AW-1:0] mapped;

   // ----------------------------------------------------------------
   // Per-window compare
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NUM_WIN; gi = gi + 1) begin : g_win
         logic [31:0] off;
         assign off = look_addr - s_r.base[gi];
         // Type, enable and range test
         assign match[gi] = s_r.en[gi] && (look_io == (gi < NUM_IO_WIN))
            && (look_addr >= s_r.base[gi]) && (look_addr <= s_r.limit[gi]);
         // Memory windows relocate, I/O passes the port number as is
         assign mapped[gi] = (gi < NUM_IO_WIN) ? look_addr[ISA_AW-1:0]
            : s_r.xlat[gi] + off[ISA_AW-1:0];
      end
   endgenerate

   // Priority pick of the first match
   always_comb begin
      hit = 1'b0;
      hit_isa_addr = '0;
      for (int i = NUM_WIN - 1; i >= 0; i--) begin
         if (match[i]) begin
            hit = 1'b1;
            hit_isa_addr = mapped[i];
         end
      end
   end

   // Table update
   always_comb begin
      s_nxt = s_r;
      if (cfg_we && (cfg_idx < WIN_IDX_W'(NUM_WIN))) begin
         s_nxt.en[cfg_idx] = cfg_en;
         s_nxt.base[cfg_idx] = cfg_base;
         s_nxt.limit[cfg_idx] = cfg_limit;
         s_nxt.xlat[cfg_idx] = cfg_xlat;
      end
   end

   // Boot defaults loaded at reset
   always_ff @(posedge clock) begin
      if (srst) begin
         s_r <= '0;
         s_r.en[IO0_IDX] <= 1'b1;
         s_r.base[IO0_IDX] <= IO0_BASE;
         s_r.limit[IO0_IDX] <= IO0_LIMIT;
         s_r.en[IO1_IDX] <= 1'b1;
         s_r.base[IO1_IDX] <= IO1_BASE;
         s_r.limit[IO1_IDX] <= IO1_LIMIT;
         s_r.en[MEM0_IDX] <= 1'b1;
         s_r.base[MEM0_IDX] <= MEM0_BASE;
         s_r.limit[MEM0_IDX] <= MEM0_LIMIT;
         s_r.xlat[MEM0_IDX] <= MEM0_XLAT;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/pib_bridge.sv ----
// Purpose: Forwards host I/O and memory accesses onto a PC/104 ISA bus
// Assumes: All inputs synchronous to clock; host holds its request until ack
// Notes:   Bridge always owns the ISA bus; no DMA, no mastering
//
// Summary of operation
// - Run 8-bit and 16-bit I/O and memory cycles for accesses in enabled windows.
// - Hold the command strobe while the target pulls ready low, then finish.
// - Use a 16-bit transfer only when the target asserts its matching CS16 line.
// - Add system-memory strobes for memory cycles below the first megabyte.
// - No ISA bus mastering; the bus is never handed to a card.
// - Route only IRQ 1, 3, 4, 6, 7 and 12 to the host.
// - After reset, I/O 0x300-0x31F and 0x8000-0x80FF are forwarded.
// - Memory 20000000-200FFFFF maps to ISA 000000-0FFFFF at equal offset.
// - Six I/O and four memory windows, each rewritable by software.
// - Only configured windows forward; boot defaults load at reset.
`timescale 1ns/100ps
`default_nettype none
module pib_bridge
   import pib_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   // Window configuration port
   input wire logic cfg_we,
   input wire logic [pib_pkg::WIN_IDX_W-1:0] cfg_idx,
   input wire logic cfg_en,
   input wire logic [31:0] cfg_base,
   input wire logic [31:0] cfg_limit,
   input wire logic [pib_pkg::ISA_AW-1:0] cfg_xlat,
   // Host access port
   input wire logic host_req,
   input wire logic host_io,
   input wire logic host_write,
   input wire logic host_wide,
   input wire logic [31:0] host_addr,
   input wire logic [pib_pkg::ISA_DW-1:0] host_wdata,
   output logic host_claim,
   output logic host_ack,
   output logic [pib_pkg::ISA_DW-1:0] host_rdata,
   output logic [pib_pkg::NUM_IRQ_OUT-1:0] host_irq,
   // ISA bus
   output logic [pib_pkg::ISA_AW-1:0] isa_sa,
   output logic bale,
   output logic aen,
   output logic sbhe_n,
   output logic ior_n,
   output logic iow_n,
   output logic memr_n,
   output logic memw_n,
   output logic smemr_n,
   output logic smemw_n,
   input wire logic [pib_pkg::ISA_DW-1:0] isa_sd_i,
   output logic [pib_pkg::ISA_DW-1:0] isa_sd_o,
   output logic isa_sd_oe,
   input wire logic iochrdy,
   input wire logic iocs16_n,
   input wire logic memcs16_n,
   input wire logic [15:0] irq_in,
   input wire logic [7:0] drq,
   output logic [7:0] dack_n,
   input wire logic master_n
);
   import pib_pkg::*;

   typedef struct packed {
      pib_state_t st;
      logic [CNT_W-1:0] cnt;
      logic io;
      logic wr;
      logic wide;
      logic use16;
      logic hi_pass;
      logic [ISA_AW-1:0] addr;
      logic [ISA_DW-1:0] wdata;
      logic [ISA_DW-1:0] rdata;
      logic ack;
      logic bale;
      logic rd_str;
      logic wr_str;
      logic low_meg;
      logic sd_oe;
      logic [ISA_DW-1:0] sd_o;
      logic [NUM_IRQ_OUT-1:0] irq;
   } pib_bridge_st_t;

   pib_bridge_st_t s_r;
   pib_bridge_st_t s_nxt;
   logic win_hit;
   logic [ISA_AW-1:0] win_isa_addr;
   logic cs16_seen;

   // ----------------------------------------------------------------
   // Window table
   // ----------------------------------------------------------------
   pib_win u_win (
      .clock(clock),
      .srst(srst),
      .cfg_we(cfg_we),
      .cfg_idx(cfg_idx),
      .cfg_en(cfg_en),
      .cfg_base(cfg_base),
      .cfg_limit(cfg_limit),
      .cfg_xlat(cfg_xlat),
      .look_io(host_io),
      .look_addr(host_addr),
      .hit(win_hit),
      .hit_isa_addr(win_isa_addr)
   );

   // ----------------------------------------------------------------
   // Host side claim
   // ----------------------------------------------------------------
   assign host_claim = host_req && win_hit;

   // Width answer of the addressed card
   assign cs16_seen = s_r.io ? !iocs16_n : !memcs16_n;

   // ----------------------------------------------------------------
   // Cycle engine
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      // Only the six supported lines reach the host
      for (int i = 0; i < NUM_IRQ_OUT; i++) begin
         s_nxt.irq[i] = irq_in[IRQ_SEL[i]];
      end
      case (s_r.st)
         ST_IDLE: begin
            // Start only for a claimed access
            if (host_claim) begin
               s_nxt.st = ST_ADDR;
               s_nxt.io = host_io;
               s_nxt.wr = host_write;
               s_nxt.wide = host_wide;
               s_nxt.hi_pass = 1'b0;
               s_nxt.addr = win_isa_addr;
               s_nxt.wdata = host_wdata;
               s_nxt.rdata = '0;
               s_nxt.bale = 1'b1;
               s_nxt.low_meg = !host_io && (win_isa_addr <= LOW_MEG_TOP);
            end
         end
         ST_ADDR: begin
            // Address settled; pick width and raise the command
            s_nxt.bale = 1'b0;
            s_nxt.use16 = s_r.wide && !s_r.hi_pass && cs16_seen;
            s_nxt.rd_str = !s_r.wr;
            s_nxt.wr_str = s_r.wr;
            s_nxt.sd_oe = s_r.wr;
            s_nxt.sd_o = s_r.hi_pass ? {8'h00, s_r.wdata[15:8]} : s_r.wdata;
            s_nxt.cnt = CNT_W'(CMD_CYC - 1);
            s_nxt.st = ST_CMD;
         end
         ST_CMD: begin
            // Least strobe width, then stretch while not ready
            if (s_r.cnt != '0) begin
               s_nxt.cnt = s_r.cnt - CNT_W'(1);
            end else if (iochrdy) begin
               s_nxt.st = ST_END;
               s_nxt.rd_str = 1'b0;
               s_nxt.wr_str = 1'b0;
               if (!s_r.wr) begin
                  if (s_r.use16) begin
                     s_nxt.rdata = isa_sd_i;
                  end else if (s_r.hi_pass) begin
                     s_nxt.rdata[15:8] = isa_sd_i[7:0];
                  end else begin
                     s_nxt.rdata[7:0] = isa_sd_i[7:0];
                  end
               end
            end
         end
         ST_END: begin
            // Data hold, then second byte or finish
            s_nxt.sd_oe = 1'b0;
            s_nxt.cnt = CNT_W'(REC_CYC - 1);
            s_nxt.st = ST_REC;
         end
         ST_REC: begin
            if (s_r.cnt != '0) begin
               s_nxt.cnt = s_r.cnt - CNT_W'(1);
            end else if (s_r.wide && !s_r.use16 && !s_r.hi_pass) begin
               // Narrow card: high byte as a second 8-bit cycle
               s_nxt.hi_pass = 1'b1;
               s_nxt.addr = s_r.addr + ISA_AW'(1);
               s_nxt.low_meg = !s_r.io && ((s_r.addr + ISA_AW'(1)) <= LOW_MEG_TOP);
               s_nxt.bale = 1'b1;
               s_nxt.st = ST_ADDR;
            end else begin
               s_nxt.ack = 1'b1;
               s_nxt.use16 = 1'b0;
               s_nxt.st = ST_IDLE;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock) begin
      if (srst) begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign host_ack = s_r.ack;
   assign host_rdata = s_r.rdata;
   assign host_irq = s_r.irq;
   assign isa_sa = s_r.addr;
   assign bale = s_r.bale;
   assign isa_sd_o = s_r.sd_o;
   assign isa_sd_oe = s_r.sd_oe;
   assign sbhe_n = !(s_r.wide && !s_r.hi_pass && (s_r.st != ST_IDLE));
   // Command strobes
   assign ior_n = !(s_r.io && s_r.rd_str);
   assign iow_n = !(s_r.io && s_r.wr_str);
   assign memr_n = !(!s_r.io && s_r.rd_str);
   assign memw_n = !(!s_r.io && s_r.wr_str);
   assign smemr_n = !(!s_r.io && s_r.rd_str && s_r.low_meg);
   assign smemw_n = !(!s_r.io && s_r.wr_str && s_r.low_meg);
   // Bridge keeps the bus; DMA requests and master requests go unanswered
   assign dack_n = 8'hff;
   assign aen = 1'b0;

endmodule
`default_nettype wire

// ---- testbench/pib_bridge_assertions.sv ----
// Purpose: Port assertions for the host to ISA window bridge
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every bridge instance
`timescale 1ns/100ps
`default_nettype none
module pib_bridge_chk
   import pib_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic host_req,
   input wire logic host_claim,
   input wire logic host_ack,
   input wire logic [pib_pkg::NUM_IRQ_OUT-1:0] host_irq,
   input wire logic [15:0] irq_in,
   input wire logic [pib_pkg::ISA_AW-1:0] isa_sa,
   input wire logic bale,
   input wire logic aen,
   input wire logic ior_n,
   input wire logic iow_n,
   input wire logic memr_n,
   input wire logic memw_n,
   input wire logic smemr_n,
   input wire logic smemw_n,
   input wire logic isa_sd_oe,
   input wire logic iochrdy,
   input wire logic [7:0] dack_n
);
   logic idle;
   // All command strobes released
   assign idle = ior_n & iow_n & memr_n & memw_n;
   default clocking @(posedge clock);
   endclocking
   default disable iff (srst);
   // Address phase, then command
   sequence s_addr_cmd;
      bale ##1 !idle;
   endsequence
   sequence s_cmd_run;
      !idle [*5];
   endsequence
   chk_addr_then_cmd: assert property (bale |-> s_addr_cmd)
      else $error("no command after address phase");
   chk_cmd_width: assert property ($fell(idle) |-> s_cmd_run)
      else $error("command strobe too short");
   chk_wait_hold: assert property ($rose(idle) |-> $past(iochrdy))
      else $error("command ended while not ready");
   chk_smem_read: assert property (smemr_n == (memr_n || isa_sa > LOW_MEG_TOP))
      else $error("low memory read strobe wrong");
   chk_smem_write: assert property (smemw_n == (memw_n || isa_sa > LOW_MEG_TOP))
      else $error("low memory write strobe wrong");
   chk_write_drive: assert property (!(iow_n && memw_n) |-> isa_sd_oe)
      else $error("write without data drive");
   chk_no_dma: assert property (dack_n == 8'hff)
      else $error("dma acknowledge given");
   chk_bus_owned: assert property (!aen)
      else $error("bus handed over");
   chk_irq_route: assert property (1'b1 |=> host_irq ==
      $past({irq_in[12], irq_in[7], irq_in[6], irq_in[4], irq_in[3], irq_in[1]}))
      else $error("interrupt routing wrong");
   chk_claim_first: assert property ($rose(bale) |-> $past(host_claim))
      else $error("cycle started without claim");
   // Host may drop its request as soon as the acknowledge shows
   chk_ack_pulse: assert property (host_ack |-> $past(host_req) ##1 !host_ack)
      else $error("acknowledge not a single pulse");
endmodule
bind pib_bridge pib_bridge_chk pib_bridge_chk_i (.clock(clock), .srst(srst),
   .host_req(host_req), .host_claim(host_claim), .host_ack(host_ack),
   .host_irq(host_irq), .irq_in(irq_in), .isa_sa(isa_sa), .bale(bale), .aen(aen),
   .ior_n(ior_n), .iow_n(iow_n), .memr_n(memr_n), .memw_n(memw_n), .smemr_n(smemr_n),
   .smemw_n(smemw_n), .isa_sd_oe(isa_sd_oe), .iochrdy(iochrdy), .dack_n(dack_n));
`default_nettype wire

// ---- testbench/pib_card_model.sv ----
// Purpose: Behavioural ISA card behind the bridge
// Assumes: Bridge always owns the bus
// Notes:   Sixteen byte places decoded by the low address bits
`timescale 1ns/100ps
`default_nettype none
module pib_card_model
   import pib_pkg::*;
(
   input wire logic clock,
   input wire logic wide,
   input wire logic [3:0] waits,
   input wire logic [pib_pkg::ISA_AW-1:0] isa_sa,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [pib_pkg::ISA_DW-1:0] isa_sd_o,
   output logic [pib_pkg::ISA_DW-1:0] isa_sd_i,
   output logic iochrdy,
   output logic cs16_n
);
   logic [7:0] mem [16];
   logic [3:0] cnt = 4'h0;
   logic [15:0] last = 16'h0;
   logic [3:0] a;
   assign a = isa_sa[3:0];
   // Answers 16-bit only when set wide; never requests DMA or the bus
   assign cs16_n = !wide;
   // Ready held low for waits cycles of each command
   assign iochrdy = (rd_n && wr_n) || cnt == 4'h0;
   // Released data lines show the inverse of the last value
   assign isa_sd_i = rd_n ? ~last : {wide ? mem[a + 4'h1] : ~last[15:8], mem[a]};
   // Wait count, store and line history
   always @(posedge clock) begin
      last <= isa_sd_i;
      if (rd_n && wr_n)
         cnt <= waits;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
      if (!wr_n) begin
         mem[a] <= isa_sd_o[7:0];
         if (wide)
            mem[a + 4'h1] <= isa_sd_o[15:8];
      end
   end
endmodule
`default_nettype wire

// ---- testbench/tb_pib_bridge.sv ----
// Purpose: Self-checking bench for the host to ISA window bridge
// Assumes: Card model answers every forwarded cycle
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
module tb_pib_bridge;
   import pib_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic cfg_we = 1'b0;
   logic cfg_en = 1'b0;
   logic [3:0] cfg_idx = 4'h0;
   logic [31:0] cfg_base = 32'h0;
   logic [31:0] cfg_limit = 32'h0;
   logic [23:0] cfg_xlat = 24'h0;
   logic host_req = 1'b0;
   logic host_io = 1'b0;
   logic host_write = 1'b0;
   logic host_wide = 1'b0;
   logic [31:0] host_addr = 32'h0;
   logic [15:0] host_wdata = 16'h0;
   logic [15:0] irq_in = 16'h0;
   logic [7:0] drq = 8'h00;
   logic card_wide = 1'b0;
   logic [3:0] card_waits = 4'h0;
   logic host_claim, host_ack, bale, aen, sbhe_n, ior_n, iow_n, memr_n, memw_n;
   logic smemr_n, smemw_n, isa_sd_oe, iochrdy, cs16_n;
   logic [15:0] host_rdata, isa_sd_i, isa_sd_o, rd;
   logic [5:0] host_irq;
   logic [23:0] isa_sa, last_sa;
   logic [7:0] dack_n;
   int n_smem = 0;
   int n_hi = 0;
   int n_claim = 0;
   int failures = 0;
   int n_checks = 0;
   int n_bale = 0;
   int n;
   always #25 clock = ~clock;
   pib_bridge pib_bridge_i (.clock(clock), .srst(srst), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
      .cfg_en(cfg_en), .cfg_base(cfg_base), .cfg_limit(cfg_limit), .cfg_xlat(cfg_xlat),
      .host_req(host_req), .host_io(host_io), .host_write(host_write),
      .host_wide(host_wide), .host_addr(host_addr), .host_wdata(host_wdata),
      .host_claim(host_claim), .host_ack(host_ack), .host_rdata(host_rdata),
      .host_irq(host_irq), .isa_sa(isa_sa), .bale(bale), .aen(aen), .sbhe_n(sbhe_n),
      .ior_n(ior_n), .iow_n(iow_n), .memr_n(memr_n), .memw_n(memw_n), .smemr_n(smemr_n),
      .smemw_n(smemw_n), .isa_sd_i(isa_sd_i), .isa_sd_o(isa_sd_o), .isa_sd_oe(isa_sd_oe),
      .iochrdy(iochrdy), .iocs16_n(cs16_n), .memcs16_n(cs16_n), .irq_in(irq_in),
      .drq(drq), .dack_n(dack_n), .master_n(1'b1));
   pib_card_model pib_card_model_i (.clock(clock), .wide(card_wide), .waits(card_waits),
      .isa_sa(isa_sa), .rd_n(ior_n & memr_n), .wr_n(iow_n & memw_n),
      .isa_sd_o(isa_sd_o), .isa_sd_i(isa_sd_i), .iochrdy(iochrdy), .cs16_n(cs16_n));
   // Track address phases, high byte enables, claims and low memory strobes
   always @(posedge clock) begin
      if (bale) begin
         n_bale <= n_bale + 1;
         last_sa <= isa_sa;
      end
      if (bale && !sbhe_n)
         n_hi <= n_hi + 1;
      if (host_claim)
         n_claim <= n_claim + 1;
      if (!smemr_n || !smemw_n)
         n_smem <= n_smem + 1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      if (failures == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // One host access held until acknowledge; n counts edges
   task automatic acc(input logic io, wr, wd, input logic [31:0] ad, input logic [15:0] wv);
      host_io = io;
      host_write = wr;
      host_wide = wd;
      host_addr = ad;
      host_wdata = wv;
      host_req = 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (host_ack !== 1'b1 && n < 60);
      rd = host_rdata;
      @(negedge clock);
      host_req = 1'b0;
      @(negedge clock); // One idle edge before the next request
   endtask
   task automatic cfg(input logic [3:0] i, input logic en, input logic [31:0] b, l,
         input logic [23:0] x);
      cfg_idx = i;
      cfg_en = en;
      cfg_base = b;
      cfg_limit = l;
      cfg_xlat = x;
      cfg_we = 1'b1;
      @(negedge clock);
      cfg_we = 1'b0;
   endtask
   // Unclaimed access: no acknowledge and no bus cycle
   task automatic miss(input logic io, input logic [31:0] ad);
      int b0;
      int c0;
      b0 = n_bale;
      c0 = n_claim;
      acc(io, 1'b0, 1'b0, ad, 16'h0);
      check(n, 60);
      check(n_bale - b0, 0);
      check(n_claim - c0, 0);
   endtask
   // Default I/O windows at their edges, both widths
   task automatic t_io;
      logic [31:0] ad [4] = '{32'h300, 32'h31f, 32'h8000, 32'h80ff};
      logic [15:0] wv;
      for (int i = 0; i < 4; i++) begin
         card_wide = i[0];
         wv = 16'h5a10 + 16'(i);
         acc(1'b1, 1'b1, i[0], ad[i], wv);
         check(n, 10);
         acc(1'b1, 1'b0, i[0], ad[i], 16'h0);
         check(i[0] ? rd : {8'h0, rd[7:0]}, i[0] ? wv : {8'h0, wv[7:0]});
      end
   endtask
   // Word to a byte-wide card splits, then slow card stretches
   task automatic t_split_wait;
      int b0;
      int h0;
      card_wide = 1'b0;
      acc(1'b1, 1'b1, 1'b1, 32'h304, 16'hbeef);
      b0 = n_bale;
      h0 = n_hi;
      acc(1'b1, 1'b0, 1'b1, 32'h304, 16'h0);
      check(rd, 16'hbeef);
      check(n_bale - b0, 2);
      check(n_hi - h0, 1);
      card_waits = 4'h8;
      // Card ready comes four edges past the least strobe width
      acc(1'b1, 1'b1, 1'b0, 32'h310, 16'h003c);
      check(n, 14);
      check(n_hi - h0, 1);
      acc(1'b1, 1'b0, 1'b0, 32'h310, 16'h0);
      check(rd[7:0], 8'h3c);
      card_waits = 4'h0;
   endtask
   // Default memory window at its top, then outside it
   task automatic t_mem;
      int s0;
      card_wide = 1'b1;
      s0 = n_smem;
      acc(1'b0, 1'b1, 1'b1, 32'h200f_fffe, 16'h1234);
      check(last_sa, 24'h0f_fffe);
      check(n_smem - s0, CMD_CYC);
      acc(1'b0, 1'b0, 1'b1, 32'h200f_fffe, 16'h0);
      check(rd, 16'h1234);
      miss(1'b0, 32'h2010_0000);
      miss(1'b1, 32'h320);
      miss(1'b0, 32'h300);
   endtask
   // New windows, disabled default, ignored index
   task automatic t_cfg;
      int s0;
      cfg(4'h2, 1'b1, 32'h400, 32'h40f, 24'h0);
      acc(1'b1, 1'b1, 1'b0, 32'h408, 16'h0011);
      check({n[7:0], last_sa}, {8'h0a, 24'h00_0408});
      cfg(4'h9, 1'b1, 32'h3000_0000, 32'h3000_ffff, 24'h20_0000);
      s0 = n_smem;
      acc(1'b0, 1'b1, 1'b0, 32'h3000_0010, 16'h0022);
      check(last_sa, 24'h20_0010);
      check(n_smem - s0, 0);
      cfg(4'h0, 1'b0, 32'h300, 32'h31f, 24'h0);
      miss(1'b1, 32'h300);
      cfg(4'ha, 1'b1, 32'h500, 32'h50f, 24'h0);
      miss(1'b1, 32'h500);
   endtask
   // Every interrupt line alone, DMA requests raised meanwhile
   task automatic t_irq;
      drq = 8'hff;
      for (int k = 0; k < 16; k++) begin
         irq_in = 16'h1 << k;
         repeat (2) @(negedge clock);
         check(host_irq, {k == 12, k == 7, k == 6, k == 4, k == 3, k == 1});
         check(dack_n, 8'hff);
      end
      irq_in = 16'h0;
      drq = 8'h00;
   endtask
   initial begin
      repeat (10) @(negedge clock);
      srst = 1'b0;
      check({aen, dack_n, ior_n, iow_n, memr_n, memw_n, bale}, 14'h1ffe);
      t_io();
      t_split_wait();
      t_mem();
      t_cfg();
      t_irq();
      conclude();
   end
   // Hang guard well past the expected run
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
